// ---- logic/tcp_pkg.sv ----
package tcp_pkg;
  // waveform_mode_select encodings
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_FP8 = 4'h5;
  localparam logic [3:0] MODE_FP9 = 4'h6;
  localparam logic [3:0] MODE_FP10 = 4'h7;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_FP_CAP = 4'hE;
  localparam logic [3:0] MODE_FP_A = 4'hF;
  // compare_output_action encodings
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // fixed TOP, MAX and BOTTOM values
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  // register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h1;
  localparam logic [3:0] ADDR_CMP_A = 4'h2;
  localparam logic [3:0] ADDR_CMP_B = 4'h3;
  localparam logic [3:0] ADDR_CAPTURE = 4'h4;
  localparam logic [3:0] ADDR_FLAGS = 4'h5;
  localparam logic [3:0] ADDR_DIVIDE = 4'h6;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_DIVIDE = 16'h0000;
  // control register field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACT_A_LSB = 4;
  localparam int CTRL_ACT_B_LSB = 6;
  localparam int CTRL_DIR_A = 8;
  localparam int CTRL_DIR_B = 9;
  localparam int CTRL_PORT_A = 10;
  localparam int CTRL_PORT_B = 11;
  // flag register positions
  localparam int FLG_OVF = 0;
  localparam int FLG_CMP_A = 1;
  localparam int FLG_CMP_B = 2;
  localparam int FLG_CAP = 3;
endpackage

// ---- logic/tcp_pwm.sv ----
`timescale 1ns/1ns
// Function
// - ctc clears counter on match of mode source
// - ctc sets top register flag at top
// - ctc top unbuffered, late write wraps through max
// - ctc action 1 toggles channel a
// - pin driven only while direction bit set
// - ctc overflow flag set on max rollover
// - fast pwm top per mode select
// - count up to top, clear next tick
// - action 2 clear/set bottom, 3 inverse
// - fast pwm overflow and top flag at top
// - fixed top masks compare bits on write
// - compare a buffered, loaded at top
// - capture top takes effect immediately
// - zero gives spike, top gives constant level
// - fast pwm toggle only in mode 15
// - ctc toggle period two n times cmp+1
// - cmp zero toggles every tick
// - pwm period n times top plus one
// - counter write blocks match next tick
// - reset clears channel output registers
// - nonzero action overrides port function
module tcp_pwm
  import tcp_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  output logic PIN_A_O,
  output logic PIN_A_OE_O,
  output logic PIN_B_O,
  output logic PIN_B_OE_O
);

  // ==========================================================
  // reset release
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ==========================================================
  // register state
  logic [11:0] ctrl_q;
  logic [15:0] count_q, cmp_a_q, cmp_a_buf_q, cmp_b_q, capture_q, divide_q, div_cnt_q;
  logic [3:0] flags_q;
  logic out_a_q, out_b_q, block_q;
  logic tick;

  wire [3:0] mode = ctrl_q[CTRL_MODE_LSB +: 4];
  wire [1:0] act_a = ctrl_q[CTRL_ACT_A_LSB +: 2];
  wire [1:0] act_b = ctrl_q[CTRL_ACT_B_LSB +: 2];
  wire wr_ctrl = WR_I && ADDR_I == ADDR_CTRL;
  wire wr_count = WR_I && ADDR_I == ADDR_COUNT;
  wire wr_flags = WR_I && ADDR_I == ADDR_FLAGS;

  function automatic logic is_fast(input logic [3:0] m);
    return m == MODE_FP8 || m == MODE_FP9 || m == MODE_FP10 || m == MODE_FP_CAP || m == MODE_FP_A;
  endfunction

  function automatic logic is_ctc(input logic [3:0] m);
    return m == MODE_CTC_A || m == MODE_CTC_CAP;
  endfunction

  // mask for fixed-top resolution; all ones when top is register defined
  function automatic logic [15:0] res_mask(input logic [3:0] m);
    case (m)
      MODE_FP8: return TOP_8BIT;
      MODE_FP9: return TOP_9BIT;
      MODE_FP10: return TOP_10BIT;
      default: return CNT_MAX;
    endcase
  endfunction

  wire fast = is_fast(mode);
  wire clear_on_match_mode = is_ctc(mode);
  wire top_is_a = mode == MODE_CTC_A || mode == MODE_FP_A;
  wire top_is_cap = mode == MODE_CTC_CAP || mode == MODE_FP_CAP;

  // ==========================================================
  // top and match detection
  logic [15:0] top_val;
  always_comb begin
    case (mode)
      MODE_FP8: top_val = TOP_8BIT;
      MODE_FP9: top_val = TOP_9BIT;
      MODE_FP10: top_val = TOP_10BIT;
      MODE_CTC_CAP, MODE_FP_CAP: top_val = capture_q;
      default: top_val = cmp_a_q;
    endcase
  end

  // matches compare the live registers, so an unbuffered top written below
  // the count is simply missed and the counter runs on to max
  wire at_top = (clear_on_match_mode || fast) && count_q == top_val && !block_q;
  wire match_a = count_q == cmp_a_q && !block_q;
  wire match_b = count_q == cmp_b_q && !block_q;
  wire at_max = count_q == CNT_MAX;

  // ==========================================================
  // prescaler: tick every divide_q+1 clocks
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_cnt_q <= RST_DIVIDE;
    end else if (div_cnt_q >= divide_q) begin
      div_cnt_q <= RST_DIVIDE;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end
  assign tick = div_cnt_q >= divide_q;

  // ==========================================================
  // counter
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_q <= RST_WORD;
    end else if (wr_count) begin
      count_q <= WDATA_I;
    end else if (tick) begin
      if (at_top) begin
        count_q <= CNT_BOTTOM;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // write blocks matches and top on the next timer tick, however many clocks away
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // ==========================================================
  // compare and capture registers
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmp_a_buf_q <= RST_WORD;
      cmp_a_q <= RST_WORD;
      cmp_b_q <= RST_WORD;
      capture_q <= RST_WORD;
    end else begin
      if (WR_I && ADDR_I == ADDR_CMP_A) begin
        cmp_a_buf_q <= WDATA_I & res_mask(mode);
        if (!fast) begin
          cmp_a_q <= WDATA_I & res_mask(mode);
        end
      end
      if (WR_I && ADDR_I == ADDR_CMP_B) begin
        cmp_b_q <= WDATA_I & res_mask(mode);
      end
      if (WR_I && ADDR_I == ADDR_CAPTURE) begin
        capture_q <= WDATA_I;
      end
      if (fast && tick && at_top) begin
        cmp_a_q <= cmp_a_buf_q;
      end
    end
  end

  // ==========================================================
  // flags: hardware set wins over a software write-one clear
  logic [3:0] set_flags;
  always_comb begin
    set_flags = '0;
    if (tick) begin
      if (clear_on_match_mode && at_max) begin
        set_flags[FLG_OVF] = 1'b1;
      end
      if (fast && at_top) begin
        set_flags[FLG_OVF] = 1'b1;
      end
      if (at_top && top_is_cap) begin
        set_flags[FLG_CAP] = 1'b1;
      end
      if ((at_top && top_is_a) || match_a) begin
        set_flags[FLG_CMP_A] = 1'b1;
      end
      if (match_b) begin
        set_flags[FLG_CMP_B] = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flags_q <= '0;
    end else if (wr_flags) begin
      flags_q <= (flags_q & ~WDATA_I[3:0]) | set_flags;
    end else begin
      flags_q <= flags_q | set_flags;
    end
  end

  // ==========================================================
  // waveform outputs
  function automatic logic next_out(input logic cur, input logic [1:0] act, input logic match,
                                    input logic bottom, input logic tog_ok);
    logic r;
    r = cur;
    if (fast) begin
      if (act == ACT_TOGGLE && tog_ok && match) begin
        r = ~cur;
      end else if (act == ACT_CLEAR) begin
        // match wins: compare equal to top yields a steady level
        if (match) r = 1'b0;
        else if (bottom) r = 1'b1;
      end else if (act == ACT_SET) begin
        if (match) r = 1'b1;
        else if (bottom) r = 1'b0;
      end
    end else if (match) begin
      case (act)
        ACT_TOGGLE: r = ~cur;
        ACT_CLEAR: r = 1'b0;
        ACT_SET: r = 1'b1;
        default: r = cur;
      endcase
    end
    return r;
  endfunction

  // bottom is the tick on which the counter clears from top
  wire bottom = fast && at_top;

  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else if (tick) begin
      out_a_q <= next_out(out_a_q, act_a, match_a, bottom, mode == MODE_FP_A);
      out_b_q <= next_out(out_b_q, act_b, match_b, bottom, 1'b0);
    end
  end

  // ==========================================================
  // pins and control
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= '0;
      divide_q <= RST_DIVIDE;
    end else begin
      if (wr_ctrl) ctrl_q <= WDATA_I[11:0];
      if (WR_I && ADDR_I == ADDR_DIVIDE) divide_q <= WDATA_I;
    end
  end

  // registered pins lag the internal output by one clock
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PIN_A_O <= 1'b0;
      PIN_B_O <= 1'b0;
      PIN_A_OE_O <= 1'b0;
      PIN_B_OE_O <= 1'b0;
    end else begin
      PIN_A_O <= (act_a != ACT_NONE) ? out_a_q : ctrl_q[CTRL_PORT_A];
      PIN_B_O <= (act_b != ACT_NONE) ? out_b_q : ctrl_q[CTRL_PORT_B];
      PIN_A_OE_O <= ctrl_q[CTRL_DIR_A];
      PIN_B_OE_O <= ctrl_q[CTRL_DIR_B];
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      RDATA_O <= '0;
    end else if (RD_I) begin
      case (ADDR_I)
        ADDR_CTRL: RDATA_O <= {4'h0, ctrl_q};
        ADDR_COUNT: RDATA_O <= count_q;
        ADDR_CMP_A: RDATA_O <= fast ? cmp_a_buf_q : cmp_a_q;
        ADDR_CMP_B: RDATA_O <= cmp_b_q;
        ADDR_CAPTURE: RDATA_O <= capture_q;
        ADDR_FLAGS: RDATA_O <= {12'h000, flags_q};
        ADDR_DIVIDE: RDATA_O <= divide_q;
        default: RDATA_O <= '0;
      endcase
    end else begin
      RDATA_O <= '0;
    end
  end

  // ==========================================================
  // checks
  property p_clear_at_top;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      tick && at_top && !wr_count |=> count_q == CNT_BOTTOM;
  endproperty
  a_clear_at_top: assert property (p_clear_at_top) else $error("counter not cleared after top");

  property p_ovf_fast;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      tick && fast && at_top |=> flags_q[FLG_OVF];
  endproperty
  a_ovf_fast: assert property (p_ovf_fast) else $error("overflow flag missing at top");

  property p_ovf_ctc;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      tick && clear_on_match_mode && at_max |=> flags_q[FLG_OVF];
  endproperty
  a_ovf_ctc: assert property (p_ovf_ctc) else $error("overflow flag missing at max");

  property p_buffer_load;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      tick && fast && at_top && !(WR_I && ADDR_I == ADDR_CMP_A) |=> cmp_a_q == $past(cmp_a_buf_q);
  endproperty
  a_buffer_load: assert property (p_buffer_load) else $error("compare a not loaded at top");

  property p_block;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      wr_count |=> !match_a && !at_top;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after count write");

  property p_toggle;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      tick && clear_on_match_mode && act_a == ACT_TOGGLE && match_a |=> out_a_q != $past(out_a_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("channel a did not toggle");

  property p_fast_clear;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      tick && fast && act_a == ACT_CLEAR && match_a |=> !out_a_q;
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("non-inverted output not cleared");

  property p_hold_no_tick;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      !tick && !WR_I |=> $stable(count_q) && $stable(out_a_q);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) else $error("state moved without tick");

  property p_pin_oe;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      1'b1 |=> PIN_A_OE_O == $past(ctrl_q[CTRL_DIR_A]);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable not from direction bit");

  property p_fast_set_b;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      tick && fast && act_b == ACT_SET && match_b |=> out_b_q;
  endproperty
  a_fast_set_b: assert property (p_fast_set_b) else $error("inverted output not set on match");

  property p_top_flag;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      tick && at_top && top_is_cap |=> flags_q[FLG_CAP];
  endproperty
  a_top_flag: assert property (p_top_flag) else $error("capture flag missing at top");

  // capture top is live the cycle after the write; no buffer stands in between
  property p_cap_write;
    @(posedge REF_CLK_I) disable iff (!rst_n_q)
      WR_I && ADDR_I == ADDR_CAPTURE |=> capture_q == $past(WDATA_I);
  endproperty
  a_cap_write: assert property (p_cap_write) else $error("capture top not taken at once");

  c_fast_top: cover property (@(posedge REF_CLK_I) disable iff (!rst_n_q) tick && fast && at_top);
  c_ctc_toggle: cover property (@(posedge REF_CLK_I) disable iff (!rst_n_q) tick && clear_on_match_mode && match_a);
  c_wrap: cover property (@(posedge REF_CLK_I) disable iff (!rst_n_q) tick && clear_on_match_mode && at_max);
  c_fp_toggle: cover property (@(posedge REF_CLK_I) disable iff (!rst_n_q) tick && mode == MODE_FP_A && match_a);
endmodule

// ---- verif/test_tcp_pwm.sv ----
`timescale 1ns/1ns
module test_tcp_pwm
  import tcp_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic pa, pae, pb, pbe;
  int err_count = 0;
  int check_count = 0;

  always #10 clk = ~clk;

  tcp_pwm tcp_pwm_inst (
    .REF_CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .PIN_A_O(pa), .PIN_A_OE_O(pae), .PIN_B_O(pb), .PIN_B_OE_O(pbe)
  );

  // ==========================================
  // tasks
  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wrr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rdr(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic pin(input logic b);
    return b ? pb : pa;
  endfunction

  function automatic logic [15:0] ctl(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab);
    return {6'h00, 2'h3, ab, aa, m};
  endfunction

  // waits for the level, then counts cycles it holds; bounded so a dead pin cannot hang
  task span(input logic b, input logic lvl, output int n);
    int t;
    // step off the edge so a pin launched by it is seen settled
    #1;
    n = 0;
    t = 0;
    while (pin(b) !== lvl && t < 3000) begin
      @(posedge clk);
      #1;
      t++;
    end
    while (pin(b) === lvl && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (t >= 3000 || n >= 3000) begin
      err_count++;
      $display("wrong value span expected level %0d seen timeout", lvl);
      test_done();
    end
  endtask

  // ==========================================
  // sequence
  initial begin
    logic [15:0] d;
    logic [3:0] modes [3];
    logic [15:0] tops [3];
    int n, h, l;
    modes = '{MODE_FP8, MODE_FP9, MODE_FP10};
    tops = '{TOP_8BIT, TOP_9BIT, TOP_10BIT};
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("pin_a", 16'h0000, 16'(pa));
    chk("oe_a", 16'h0000, 16'(pae));
    rdr(ADDR_CTRL, d);
    chk("ctrl", RST_WORD, d);
    rdr(4'h7, d);
    chk("unmapped", 16'h0000, d);
    wrr(ADDR_CTRL, 16'h0900);
    repeat (3) @(posedge clk);
    #1;
    chk("pin_b_port", 16'h0001, 16'(pb));
    chk("oe_b", 16'h0000, 16'(pbe));
    chk("oe_a", 16'h0001, 16'(pae));
    $display("test reset and pins done");

    wrr(ADDR_CMP_A, 16'h0009);
    wrr(ADDR_CTRL, ctl(MODE_CTC_A, ACT_TOGGLE, ACT_NONE));
    // the counter ran free since reset; restart it below the compare or it wraps through max
    wrr(ADDR_COUNT, 16'h0000);
    wrr(ADDR_FLAGS, 16'h000F);
    span(0, 1, n);
    span(0, 1, n);
    chk("ctc_high", 16'd10, 16'(n));
    span(0, 0, n);
    chk("ctc_low", 16'd10, 16'(n));
    rdr(ADDR_FLAGS, d);
    chk("flag_a", 16'h0001, 16'(d[FLG_CMP_A]));
    wrr(ADDR_DIVIDE, 16'h0001);
    span(0, 1, n);
    span(0, 1, n);
    chk("ctc_div2", 16'd20, 16'(n));
    wrr(ADDR_DIVIDE, 16'h0000);
    wrr(ADDR_FLAGS, 16'h000F);
    // top below the count: the match is missed until the counter wraps
    wrr(ADDR_COUNT, 16'hFFF0);
    wrr(ADDR_CMP_A, 16'h0000);
    repeat (30) @(posedge clk);
    rdr(ADDR_FLAGS, d);
    chk("flag_ovf", 16'h0001, 16'(d[FLG_OVF]));
    span(0, 1, n);
    span(0, 1, n);
    chk("ctc_zero", 16'd1, 16'(n));
    wrr(ADDR_CMP_A, 16'h0003);
    wrr(ADDR_CAPTURE, 16'd14);
    wrr(ADDR_CTRL, ctl(MODE_CTC_CAP, ACT_TOGGLE, ACT_NONE));
    wrr(ADDR_FLAGS, 16'h000F);
    span(0, 1, n);
    span(0, 1, n);
    chk("ctc_cap", 16'd15, 16'(n));
    rdr(ADDR_FLAGS, d);
    chk("flag_cap", 16'h0001, 16'(d[FLG_CAP]));
    wrr(ADDR_CTRL, ctl(MODE_CTC_CAP, ACT_SET, ACT_NONE));
    repeat (20) @(posedge clk);
    #1;
    chk("ctc_set", 16'h0001, 16'(pa));
    wrr(ADDR_CTRL, ctl(MODE_CTC_CAP, ACT_CLEAR, ACT_NONE));
    repeat (20) @(posedge clk);
    #1;
    chk("ctc_clear", 16'h0000, 16'(pa));
    $display("test clear on match done");

    wrr(ADDR_CTRL, ctl(MODE_FP8, ACT_NONE, ACT_CLEAR));
    wrr(ADDR_CMP_B, 16'h1234);
    rdr(ADDR_CMP_B, d);
    chk("cmp_b_mask", 16'h0034, d);
    wrr(ADDR_CMP_B, 16'h0000);
    span(1, 0, l);
    span(1, 1, h);
    chk("spike", 16'd1, 16'(h));
    wrr(ADDR_CTRL, ctl(MODE_FP8, ACT_NONE, ACT_SET));
    wrr(ADDR_CMP_B, 16'h0010);
    span(1, 1, h);
    span(1, 0, l);
    chk("inv_low", 16'd17, 16'(l));
    wrr(ADDR_FLAGS, 16'h000F);
    for (int i = 0; i < 3; i++) begin
      wrr(ADDR_CTRL, ctl(modes[i], ACT_CLEAR, ACT_CLEAR));
      span(1, 1, h);
      span(1, 0, l);
      span(1, 1, h);
      chk("pwm_high", 16'd17, 16'(h));
      chk("pwm_period", tops[i] + 16'h0001, 16'(h + l));
    end
    rdr(ADDR_FLAGS, d);
    chk("flag_ovf_pwm", 16'h0001, 16'(d[FLG_OVF]));
    wrr(ADDR_CAPTURE, 16'd99);
    wrr(ADDR_COUNT, 16'h0000);
    wrr(ADDR_CTRL, ctl(MODE_FP_CAP, ACT_NONE, ACT_CLEAR));
    wrr(ADDR_FLAGS, 16'h000F);
    span(1, 1, h);
    span(1, 0, l);
    span(1, 1, h);
    chk("cap_period", 16'd100, 16'(h + l));
    rdr(ADDR_FLAGS, d);
    chk("flag_cap_pwm", 16'h0001, 16'(d[FLG_CAP]));
    // let a top pass so the buffered compare value is active before the switch
    wrr(ADDR_CMP_A, 16'd19);
    repeat (110) @(posedge clk);
    wrr(ADDR_COUNT, 16'h0000);
    wrr(ADDR_CTRL, ctl(MODE_FP_A, ACT_TOGGLE, ACT_CLEAR));
    span(0, 1, n);
    span(0, 1, n);
    chk("fp_toggle", 16'd20, 16'(n));
    span(0, 0, n);
    wrr(ADDR_CMP_A, 16'd49);
    span(0, 1, n);
    chk("old_top_kept", 16'h0001, 16'(n < 20));
    span(0, 0, n);
    chk("new_top", 16'd50, 16'(n));
    $display("test fast pwm done");
    test_done();
  end
endmodule
